// >>> pcssc_pkg.sv
// Package for the PCS status and SERDES side-band block.
// Assumes a single 10 MHz clock and synchronous active-high reset.
package pcssc_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_ECC = 4'h2;
   localparam logic [3:0] ADDR_ABILITY = 4'h3;

   // Control register fields
   localparam int CTRL_AN_EN = 0;
   localparam int CTRL_SGMII = 1;
   localparam int CTRL_SGMII_PHY = 2;
   localparam int CTRL_HALF_DUP = 3;
   localparam int CTRL_PWRDN = 4;
   localparam int CTRL_LOOP = 5;
   localparam int CTRL_EXT_SERDES = 6;
   localparam int CTRL_LOCK_DATA = 7;
   localparam int CTRL_LOCK_REF = 8;
   localparam int CTRL_TX_DRST = 9;
   localparam int CTRL_RX_DRST = 10;
   localparam logic [10:0] CTRL_RST = 11'h040;

   // Ability word bit that carries link state
   localparam int ABIL_LINK_BIT = 15;

   // ----------------------------------------
   // ECC status encoding
   // ----------------------------------------
   localparam logic [1:0] ECC_NONE = 2'h0;
   localparam logic [1:0] ECC_BAD = 2'h1;
   localparam logic [1:0] ECC_CORR = 2'h2;
   localparam logic [1:0] ECC_UNCORR = 2'h3;

   // Clock figures
   localparam int CLK_MHZ = 10;
   localparam int ERR_PULSE_CYC = 1;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic link;
      logic panel_link;
      logic crs;
      logic col;
      logic an;
   } pcssc_leds_t;

   typedef struct packed {
      logic tx_cal_busy;
      logic rx_cal_busy;
      logic data_locked;
      logic ref_locked;
   } pcssc_xcvr_t;

   typedef enum logic [2:0] {
      AN_IDLE = 3'b001,
      AN_RUN = 3'b010,
      AN_DONE = 3'b100
   } pcssc_an_t;

endpackage

// >>> pcssc_top.sv
// PCS status indicators, error pulses, SERDES side-band and ECC status.
// Assumes all inputs synchronous to I_MCLK; the ten-bit receive clock
// is represented by I_MCLK in this single-clock build.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps

// Function
// - Link indicator high exactly while receive synchronisation is achieved.
// - Without auto-negotiation, panel link follows link indicator in both modes.
// - 1000BASE-X with auto-negotiation: panel link follows negotiation complete.
// - SGMII MAC-side negotiation: panel link is done and partner ability bit 15.
// - SGMII PHY-side negotiation: panel link is done and local ability bit 15.
// - Carrier indicator high while traffic is present, low otherwise.
// - Collision indicator high when collision seen during frame transmission.
// - Collision indicator forced low in 1000BASE-X and full-duplex SGMII.
// - Negotiation indicator asserts once a negotiation sequence completes.
// - Invalid received code group gives a one-cycle character error pulse.
// - Running disparity error gives a one-cycle disparity error pulse.
// - Power-down output high in power-down mode, low in normal operation.
// - Power-down output only exists with an external serializer.
// - Loopback request high while the block operates in loopback mode.
// - Calibration busy outputs reflect transmit and receive calibration.
// - CDR lock to data and lock to reference reported separately.
// - ECC status codes: 11 uncorrectable, 10 corrected, 00 none, 01 invalid.
// - ECC status synchronised into the register clock domain.
module pcssc_top
(
   // Clock and reset
   input wire logic I_MCLK,
   input wire logic I_SRST,
   // Register port
   input wire logic [3:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [31:0] O_RDATA,
   // Receive path status
   input wire logic I_RX_SYNC,
   input wire logic I_AN_START,
   input wire logic I_AN_COMPLETE,
   input wire logic I_TRAFFIC,
   input wire logic I_TX_FRAME,
   input wire logic I_COLLISION,
   input wire logic I_CODE_INVALID,
   input wire logic I_DISP_BAD,
   input wire logic [1:0] I_ECC_RAW,
   // Transceiver status
   input wire logic I_TX_CAL,
   input wire logic I_RX_CAL,
   input wire logic I_CDR_DATA_LOCK,
   input wire logic I_CDR_REF_LOCK,
   // Indicators
   output logic O_LINK,
   output logic O_PANEL_LINK,
   output logic O_CRS,
   output logic O_COL,
   output logic O_AUTONEG_DONE_IND,
   output logic O_CHAR_ERR,
   output logic O_DISP_ERR,
   // SERDES side-band
   output logic O_POWERDOWN,
   output logic O_EXT_SERDES_LOOP_REQ,
   output logic O_TX_CAL_BUSY,
   output logic O_RX_CAL_BUSY,
   output logic O_CDR_DATA_LOCKED,
   output logic O_CDR_REF_LOCKED,
   output logic O_CDR_SET_LOCK_DATA,
   output logic O_CDR_SET_LOCK_REF,
   output logic O_TX_DIGITAL_RST,
   output logic O_RX_DIGITAL_RST,
   output logic [1:0] O_ECC_STATUS
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [10:0] ctrl;
   logic [15:0] dev_ability;
   logic [15:0] partner_ability;
   logic [1:0] ecc_meta;
   logic [1:0] ecc_sync;
   pcssc_pkg::pcssc_an_t an_state;
   pcssc_pkg::pcssc_leds_t leds;
   pcssc_pkg::pcssc_xcvr_t xcvr;
   logic next_panel;
   logic an_en;
   logic sgmii;

   assign an_en = ctrl[pcssc_pkg::CTRL_AN_EN];
   assign sgmii = ctrl[pcssc_pkg::CTRL_SGMII];

   function automatic logic [1:0] ecc_clean(input logic [1:0] raw);
      // The invalid code never leaves the block; treat it as no error
      ecc_clean = (raw == pcssc_pkg::ECC_BAD) ? pcssc_pkg::ECC_NONE : raw;
   endfunction

   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         ctrl <= pcssc_pkg::CTRL_RST;
         dev_ability <= 16'h0000;
      end
      else if (I_WR && I_ADDR == pcssc_pkg::ADDR_CTRL)
      begin
         ctrl <= I_WDATA[10:0];
      end
      else if (I_WR && I_ADDR == pcssc_pkg::ADDR_ABILITY)
      begin
         dev_ability <= I_WDATA[15:0];
      end
   end

   // Partner ability is written through the ability register, from the upper half of the write data
   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         partner_ability <= 16'h0000;
      end
      else if (I_WR && I_ADDR == pcssc_pkg::ADDR_ABILITY)
      begin
         partner_ability <= I_WDATA[31:16];
      end
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         O_RDATA <= 32'h00000000;
      end
      else if (I_RD)
      begin
         case (I_ADDR)
            pcssc_pkg::ADDR_CTRL: O_RDATA <= {21'h000000, ctrl};
            pcssc_pkg::ADDR_STATUS: O_RDATA <= {23'h000000, xcvr, leds};
            pcssc_pkg::ADDR_ECC: O_RDATA <= {30'h00000000, ecc_sync};
            pcssc_pkg::ADDR_ABILITY: O_RDATA <= {partner_ability, dev_ability};
            default: O_RDATA <= 32'h00000000;
         endcase
      end
      else
      begin
         O_RDATA <= 32'h00000000;
      end
   end

   // ----------------------------------------
   // Auto-negotiation tracking
   // ----------------------------------------
   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST || !an_en)
      begin
         an_state <= pcssc_pkg::AN_IDLE;
      end
      else
      begin
         case (an_state)
            pcssc_pkg::AN_IDLE: if (I_AN_START) an_state <= pcssc_pkg::AN_RUN;
            pcssc_pkg::AN_RUN: if (I_AN_COMPLETE) an_state <= pcssc_pkg::AN_DONE;
            pcssc_pkg::AN_DONE: if (I_AN_START) an_state <= pcssc_pkg::AN_RUN;
            default: an_state <= pcssc_pkg::AN_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Indicators
   // ----------------------------------------
   always_comb
   begin
      if (!an_en)
         next_panel = I_RX_SYNC;
      else if (!sgmii)
         next_panel = (an_state == pcssc_pkg::AN_DONE);
      else if (ctrl[pcssc_pkg::CTRL_SGMII_PHY])
         next_panel = (an_state == pcssc_pkg::AN_DONE) && dev_ability[pcssc_pkg::ABIL_LINK_BIT];
      else
         next_panel = (an_state == pcssc_pkg::AN_DONE) && partner_ability[pcssc_pkg::ABIL_LINK_BIT];
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         leds <= '0;
      end
      else
      begin
         leds.link <= I_RX_SYNC;
         leds.panel_link <= next_panel;
         leds.crs <= I_TRAFFIC;
         // Collisions only mean something in half-duplex SGMII
         leds.col <= sgmii && ctrl[pcssc_pkg::CTRL_HALF_DUP] && I_TX_FRAME && I_COLLISION;
         leds.an <= (an_state == pcssc_pkg::AN_DONE);
      end
   end

   // Error pulses: one cycle per detection; a held input gives one pulse
   logic code_prev;
   logic disp_prev;
   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         code_prev <= 1'b0;
         disp_prev <= 1'b0;
         O_CHAR_ERR <= 1'b0;
         O_DISP_ERR <= 1'b0;
      end
      else
      begin
         code_prev <= I_CODE_INVALID;
         disp_prev <= I_DISP_BAD;
         O_CHAR_ERR <= I_CODE_INVALID && !code_prev;
         O_DISP_ERR <= I_DISP_BAD && !disp_prev;
      end
   end

   // ----------------------------------------
   // SERDES side-band
   // ----------------------------------------
   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         O_POWERDOWN <= 1'b0;
         O_EXT_SERDES_LOOP_REQ <= 1'b0;
         xcvr <= '0;
      end
      else
      begin
         // Embedded transceiver builds leave the pin quiet
         O_POWERDOWN <= ctrl[pcssc_pkg::CTRL_PWRDN] && ctrl[pcssc_pkg::CTRL_EXT_SERDES];
         O_EXT_SERDES_LOOP_REQ <= ctrl[pcssc_pkg::CTRL_LOOP];
         xcvr.tx_cal_busy <= I_TX_CAL;
         xcvr.rx_cal_busy <= I_RX_CAL;
         xcvr.data_locked <= I_CDR_DATA_LOCK;
         xcvr.ref_locked <= I_CDR_REF_LOCK;
      end
   end

   assign O_TX_CAL_BUSY = xcvr.tx_cal_busy;
   assign O_RX_CAL_BUSY = xcvr.rx_cal_busy;
   assign O_CDR_DATA_LOCKED = xcvr.data_locked;
   assign O_CDR_REF_LOCKED = xcvr.ref_locked;
   assign O_CDR_SET_LOCK_DATA = ctrl[pcssc_pkg::CTRL_LOCK_DATA];
   assign O_CDR_SET_LOCK_REF = ctrl[pcssc_pkg::CTRL_LOCK_REF];
   assign O_TX_DIGITAL_RST = ctrl[pcssc_pkg::CTRL_TX_DRST];
   assign O_RX_DIGITAL_RST = ctrl[pcssc_pkg::CTRL_RX_DRST];

   assign O_LINK = leds.link;
   assign O_PANEL_LINK = leds.panel_link;
   assign O_CRS = leds.crs;
   assign O_COL = leds.col;
   assign O_AUTONEG_DONE_IND = leds.an;

   // ----------------------------------------
   // ECC status synchroniser
   // ----------------------------------------
   always_ff @(posedge I_MCLK)
   begin
      if (I_SRST)
      begin
         ecc_meta <= pcssc_pkg::ECC_NONE;
         ecc_sync <= pcssc_pkg::ECC_NONE;
      end
      else
      begin
         ecc_meta <= ecc_clean(I_ECC_RAW);
         ecc_sync <= ecc_meta;
      end
   end

   assign O_ECC_STATUS = ecc_sync;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_code_edge;
      !I_CODE_INVALID ##1 I_CODE_INVALID;
   endsequence

   sequence s_disp_edge;
      !I_DISP_BAD ##1 I_DISP_BAD;
   endsequence

   // Completion seen while running, with no restart right behind it
   sequence s_an_complete;
      !I_SRST && an_en && an_state == pcssc_pkg::AN_RUN && I_AN_COMPLETE ##1 an_en && !I_AN_START;
   endsequence

   // Release lands on the edge that samples it, so antecedents wait for a sampled low
   chk_link_follow: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST |=> O_LINK == $past(I_RX_SYNC))
      else $error("link indicator does not follow sync");
   chk_panel_noan: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && !an_en ##1 !$past(an_en,1) |-> O_PANEL_LINK == $past(I_RX_SYNC))
      else $error("panel link wrong without negotiation");
   chk_panel_base: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && an_en && !sgmii |=> O_PANEL_LINK == O_AUTONEG_DONE_IND)
      else $error("panel link differs from negotiation indicator");
   chk_panel_mac: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && an_en && sgmii && !ctrl[pcssc_pkg::CTRL_SGMII_PHY] |=>
      O_PANEL_LINK == (O_AUTONEG_DONE_IND && $past(partner_ability[pcssc_pkg::ABIL_LINK_BIT])))
      else $error("panel link wrong on MAC side");
   chk_panel_phy: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && an_en && sgmii && ctrl[pcssc_pkg::CTRL_SGMII_PHY] |=>
      O_PANEL_LINK == (O_AUTONEG_DONE_IND && $past(dev_ability[pcssc_pkg::ABIL_LINK_BIT])))
      else $error("panel link wrong on PHY side");
   chk_crs_follow: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST |=> O_CRS == $past(I_TRAFFIC))
      else $error("carrier indicator does not follow traffic");
   chk_col_seen: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && sgmii && ctrl[pcssc_pkg::CTRL_HALF_DUP] && I_TX_FRAME && I_COLLISION |=> O_COL)
      else $error("collision not shown");
   chk_col_block: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !sgmii || !ctrl[pcssc_pkg::CTRL_HALF_DUP] |=> !O_COL)
      else $error("collision shown outside half-duplex SGMII");
   chk_an_done: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_an_complete |=> O_AUTONEG_DONE_IND)
      else $error("negotiation indicator missed completion");
   chk_char_pulse: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_code_edge |=> O_CHAR_ERR ##1 !O_CHAR_ERR)
      else $error("character error pulse wrong");
   chk_disp_pulse: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      O_DISP_ERR |=> !O_DISP_ERR)
      else $error("disparity pulse too long");
   chk_disp_edge: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_disp_edge |=> O_DISP_ERR)
      else $error("disparity pulse missing");
   chk_pwrdn_set: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && ctrl[pcssc_pkg::CTRL_PWRDN] && ctrl[pcssc_pkg::CTRL_EXT_SERDES] |=> O_POWERDOWN)
      else $error("power-down request missing");
   chk_pwrdn_quiet: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !ctrl[pcssc_pkg::CTRL_PWRDN] || !ctrl[pcssc_pkg::CTRL_EXT_SERDES] |=> !O_POWERDOWN)
      else $error("power-down request in wrong mode");
   chk_loop_req: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST |=> O_EXT_SERDES_LOOP_REQ == $past(ctrl[pcssc_pkg::CTRL_LOOP]))
      else $error("loopback request wrong");
   chk_xcvr_copy: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST |=> {O_TX_CAL_BUSY, O_RX_CAL_BUSY, O_CDR_DATA_LOCKED, O_CDR_REF_LOCKED} ==
      $past({I_TX_CAL, I_RX_CAL, I_CDR_DATA_LOCK, I_CDR_REF_LOCK}))
      else $error("transceiver status not passed on");
   chk_ecc_valid: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      O_ECC_STATUS != pcssc_pkg::ECC_BAD)
      else $error("invalid ECC code shown");
   chk_ecc_delay: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      !I_SRST && I_ECC_RAW == pcssc_pkg::ECC_UNCORR ##1 1'b1 |=> O_ECC_STATUS == pcssc_pkg::ECC_UNCORR)
      else $error("ECC status not two cycles late");
   chk_reset_quiet: assert property (@(posedge I_MCLK)
      I_SRST |=> !O_LINK && !O_PANEL_LINK && !O_CRS && !O_COL && !O_AUTONEG_DONE_IND &&
      !O_CHAR_ERR && !O_DISP_ERR && O_ECC_STATUS == pcssc_pkg::ECC_NONE)
      else $error("outputs active after reset");

endmodule

// >>> pcssc_top_tb.sv
// Self-checking bench for the PCS status and side-band block.
// Assumes the transceiver model below; settles several cycles before comparing.
`timescale 1ns/1ps
module pcssc_top_tb;
   logic I_MCLK, I_SRST, I_WR, I_RD, I_RX_SYNC, I_AN_START, I_AN_COMPLETE, I_TRAFFIC;
   logic I_TX_FRAME, I_COLLISION, I_CODE_INVALID, I_DISP_BAD;
   wire logic I_TX_CAL, I_RX_CAL, I_CDR_DATA_LOCK, I_CDR_REF_LOCK;
   logic [3:0] I_ADDR;
   logic [31:0] I_WDATA, O_RDATA, ctrl, abil, r, d;
   logic [1:0] I_ECC_RAW, O_ECC_STATUS;
   logic O_LINK, O_PANEL_LINK, O_CRS, O_COL, O_AUTONEG_DONE_IND, O_CHAR_ERR, O_DISP_ERR;
   logic O_POWERDOWN, O_EXT_SERDES_LOOP_REQ, O_TX_CAL_BUSY, O_RX_CAL_BUSY, O_CDR_DATA_LOCKED;
   logic O_CDR_REF_LOCKED, O_CDR_SET_LOCK_DATA, O_CDR_SET_LOCK_REF, O_TX_DIGITAL_RST, O_RX_DIGITAL_RST;
   logic an_done;
   int error_cnt = 0;
   int tests_run = 0;
   int cyc = 0;
   pcssc_pkg::pcssc_xcvr_t xs;

   pcssc_top i_dut (.*);
   pcssc_xcvr_model i_xcvr (.i_clk(I_MCLK), .i_lock_data(O_CDR_SET_LOCK_DATA), .i_lock_ref(O_CDR_SET_LOCK_REF),
      .i_tx_rst(O_TX_DIGITAL_RST), .i_rx_rst(O_RX_DIGITAL_RST), .o_stat(xs));
   assign I_TX_CAL = xs.tx_cal_busy;
   assign I_RX_CAL = xs.rx_cal_busy;
   assign I_CDR_DATA_LOCK = xs.data_locked;
   assign I_CDR_REF_LOCK = xs.ref_locked;

   initial
   begin
      I_MCLK = 1'b0;
      forever #50 I_MCLK = ~I_MCLK;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard: the full sequence needs well under two thousand cycles
   always @(posedge I_MCLK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge I_MCLK);
      I_WR <= 1'b1;
      I_ADDR <= a;
      I_WDATA <= v;
      @(posedge I_MCLK);
      I_WR <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge I_MCLK);
      I_RD <= 1'b1;
      I_ADDR <= a;
      @(posedge I_MCLK);
      I_RD <= 1'b0;
      #1 v = O_RDATA;
   endtask

   // Reference model of every level output except the ECC status, from the driven inputs, ctrl and abil
   task automatic check_all();
      logic pnl, col;
      logic [3:0] x;
      if (!ctrl[0])
         pnl = I_RX_SYNC;
      else if (!ctrl[1])
         pnl = an_done;
      else
         pnl = an_done & (ctrl[2] ? abil[15] : abil[31]);
      col = I_COLLISION & I_TX_FRAME & ctrl[1] & ctrl[3];
      x = {ctrl[9], ctrl[10], ctrl[7] & ~ctrl[10], ctrl[8] & ~ctrl[10]};
      repeat (4) @(posedge I_MCLK);
      #1;
      chk("link", O_LINK, I_RX_SYNC);
      chk("panel", O_PANEL_LINK, pnl);
      chk("crs", O_CRS, I_TRAFFIC);
      chk("col", O_COL, col);
      chk("an", O_AUTONEG_DONE_IND, an_done);
      chk("pdn", O_POWERDOWN, ctrl[4] & ctrl[6]);
      chk("loop", O_EXT_SERDES_LOOP_REQ, ctrl[5]);
      chk("side", {O_CDR_SET_LOCK_DATA, O_CDR_SET_LOCK_REF, O_TX_DIGITAL_RST, O_RX_DIGITAL_RST},
         {ctrl[7], ctrl[8], ctrl[9], ctrl[10]});
      chk("xcvr", {O_TX_CAL_BUSY, O_RX_CAL_BUSY, O_CDR_DATA_LOCKED, O_CDR_REF_LOCKED}, x);
      rd(pcssc_pkg::ADDR_STATUS, d);
      chk("status", d, {23'h0, x, I_RX_SYNC, pnl, I_TRAFFIC, col, an_done});
      rd(pcssc_pkg::ADDR_CTRL, d);
      chk("ctrl", d, {21'h0, ctrl[10:0]});
      rd(pcssc_pkg::ADDR_ABILITY, d);
      chk("ability", d, abil);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {I_SRST, I_WR, I_RD, I_RX_SYNC, I_AN_START, I_AN_COMPLETE, I_TRAFFIC} = 7'h40;
      {I_TX_FRAME, I_COLLISION, I_CODE_INVALID, I_DISP_BAD} = 4'h0;
      I_ADDR = 4'h0;
      I_WDATA = 32'h0;
      I_ECC_RAW = 2'h0;
      ctrl = 32'h40;
      abil = 32'h0;
      an_done = 1'b0;
      void'($urandom(32'h303b2f90));
      repeat (6) @(posedge I_MCLK);
      I_SRST <= 1'b0;
      check_all();
      repeat (40)
      begin
         r = $urandom;
         @(posedge I_MCLK);
         I_RX_SYNC <= r[0];
         I_TRAFFIC <= r[1];
         I_TX_FRAME <= r[2];
         I_COLLISION <= r[3];
         ctrl = {21'h0, r[31:21]};
         abil = $urandom;
         wr(pcssc_pkg::ADDR_CTRL, ctrl);
         wr(pcssc_pkg::ADDR_ABILITY, abil);
         check_all();
      end
      $display("test random levels done");
      wr(4'h7, 32'hffffffff);
      rd(4'h7, d);
      chk("unmapped", d, 32'h0);
      check_all();
      $display("test unmapped done");
      ctrl = 32'h41;
      wr(pcssc_pkg::ADDR_CTRL, ctrl);
      @(posedge I_MCLK);
      I_AN_START <= 1'b1;
      @(posedge I_MCLK);
      I_AN_START <= 1'b0;
      check_all();
      @(posedge I_MCLK);
      I_AN_COMPLETE <= 1'b1;
      @(posedge I_MCLK);
      I_AN_COMPLETE <= 1'b0;
      an_done = 1'b1;
      for (int k = 0; k < 12; k++)
      begin
         ctrl = (k % 3 == 0) ? 32'h41 : (k % 3 == 1) ? 32'h43 : 32'h47;
         abil = {k[3], 15'h0, k[2], 15'h0};
         wr(pcssc_pkg::ADDR_CTRL, ctrl);
         wr(pcssc_pkg::ADDR_ABILITY, abil);
         check_all();
      end
      ctrl = 32'h40;
      an_done = 1'b0;
      wr(pcssc_pkg::ADDR_CTRL, ctrl);
      check_all();
      $display("test negotiation done");
      for (int k = 0; k < 2; k++)
      begin
         @(posedge I_MCLK);
         I_CODE_INVALID <= (k == 0);
         I_DISP_BAD <= (k == 1);
         @(posedge I_MCLK);
         #1 chk("char", O_CHAR_ERR, k == 0);
         chk("disp", O_DISP_ERR, k == 1);
         @(posedge I_MCLK);
         #1 chk("pulse end", {O_CHAR_ERR, O_DISP_ERR}, 2'b00);
         @(posedge I_MCLK);
         I_CODE_INVALID <= 1'b0;
         I_DISP_BAD <= 1'b0;
      end
      $display("test error pulses done");
      for (int v = 0; v < 4; v++)
      begin
         @(posedge I_MCLK);
         I_ECC_RAW <= v[1:0];
         repeat (3) @(posedge I_MCLK);
         #1 chk("ecc", O_ECC_STATUS, (v == 1) ? 0 : v);
         rd(pcssc_pkg::ADDR_ECC, d);
         chk("ecc reg", d, (v == 1) ? 0 : v);
      end
      $display("test ecc done");
      @(posedge I_MCLK);
      I_RX_SYNC <= 1'b1;
      I_TRAFFIC <= 1'b1;
      I_SRST <= 1'b1;
      abil = 32'h0;
      repeat (2) @(posedge I_MCLK);
      #1 chk("in reset", {O_LINK, O_PANEL_LINK, O_CRS, O_COL, O_AUTONEG_DONE_IND, O_CHAR_ERR, O_DISP_ERR,
         O_ECC_STATUS}, 9'h0);
      @(posedge I_MCLK);
      I_SRST <= 1'b0;
      check_all();
      $display("test second reset done");
      tally_and_finish();
   end
endmodule

// >>> pcssc_xcvr_model.sv
// Behavioural model of the transceiver side-band: calibration and CDR lock.
// Assumes its controls come from the block under test, all on one clock.
`timescale 1ns/1ps
module pcssc_xcvr_model
(
   // Clock
   input wire logic i_clk,
   // Controls from the block
   input wire logic i_lock_data,
   input wire logic i_lock_ref,
   input wire logic i_tx_rst,
   input wire logic i_rx_rst,
   // Status toward the block
   output pcssc_pkg::pcssc_xcvr_t o_stat
);
   // Calibration runs while a digital part is held in reset; no lock while the receive part is held
   // One clock stands in for the serial, CDR reference and ten-bit receive clocks
   always_ff @(posedge i_clk)
   begin
      o_stat.tx_cal_busy <= i_tx_rst;
      o_stat.rx_cal_busy <= i_rx_rst;
      o_stat.data_locked <= i_lock_data & ~i_rx_rst;
      o_stat.ref_locked <= i_lock_ref & ~i_rx_rst;
   end
endmodule
